// file: include/sspr_params.svh
/*
   Constants of the byte-wide serial port: register indices, byte
   addresses, control/status field positions and reset values.
   Assumes a 32-bit AHB-Lite slave with one register per aligned word.
*/
// Contract
// (RL1) Write-only 8-bit transmit buffer holds next byte to send; resets zero.
// (RL2) Read-only 8-bit receive buffer holds last completed byte; resets zero.
// (RL3) Control bit 7: 0 sends MSB first, 1 sends LSB first.
// (RL4) Software keeps order, phase, polarity fixed while enabled or busy.
// (RL5) Status bit 6 sets on unread receive overwrite; clears on status read.
// (RL6) Status bit 5 sets when byte and all clocks done; status read clears.
// (RL7) Status bit 4 reads 1 after reset and while disabled.
// (RL8) Bit 4 clears on transmit write, sets when byte enters shifter.
// (RL9) Transmit-empty interrupt fires only after first byte enters shifter.
// (RL10) Status bit 3 sets on receive load; clears on receive buffer read.
// (RL11) Control bit 2: 0 samples leading edge, 1 samples trailing edge.
// (RL12) Control bit 1: 0 clock idles low, 1 clock idles high.
// (RL13) Control bit 0 enables the port; resets to 0.
// (RL14) A write while enabled and idle starts an 8-bit transfer at once.
`ifndef SSPR_PARAMS_SVH
`define SSPR_PARAMS_SVH

`define SSPR_IDX_TXB        8'h29
`define SSPR_IDX_RXB        8'h2A
`define SSPR_IDX_CTL        8'h2B
`define SSPR_ADDR_TXB       8'hA4
`define SSPR_ADDR_RXB       8'hA8
`define SSPR_ADDR_CTL       8'hAC

`define SSPR_BIT_LSB        7
`define SSPR_BIT_OVR        6
`define SSPR_BIT_CMPL       5
`define SSPR_BIT_TXE        4
`define SSPR_BIT_RXF        3
`define SSPR_BIT_CPHA       2
`define SSPR_BIT_CPOL       1
`define SSPR_BIT_EN         0

`define SSPR_RST_TXB        8'h00
`define SSPR_RST_RXB        8'h00
`define SSPR_RST_CTL        8'h10

`define SSPR_HALF_DIV       4
`define SSPR_SYNC_LAT       2
`define SSPR_HALF_EDGES     5'h10

`endif

// file: include/sspr_pkg.sv
/*
   Types shared by the serial port: configuration carrier and the
   link-side sequencer states. Assumes nothing of its surroundings.
*/
package sspr_pkg;

   typedef struct packed {
      logic lsb_first;
      logic cpha;
      logic cpol;
   } sspr_cfg_t;

   typedef enum logic [1:0] {
      SSPR_IDLE = 2'b00,
      SSPR_RUN  = 2'b01
   } sspr_link_state_t;

endpackage

// file: logic/sspr_top.sv
/*
   Byte-wide SPI master port with transmit, receive and control/status
   registers on AHB-Lite (zero wait states, always OKAY).
   Assumes link_clk runs freely; the serial clock is divided from it.
   Configuration bits are held steady while the port is enabled.
*/
`timescale 1ns/1ps
`include "sspr_params.svh"

module sspr_top
#(
   parameter int HALF_DIV = `SSPR_HALF_DIV
)
(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             tx_empty_irq,
   input  wire logic        link_clk,
   output logic             spi_sclk,
   output logic             spi_mosi,
   output logic             spi_sel_n,
   input  wire logic        spi_miso
);
   import sspr_pkg::*;

   // A literal cannot be bit-selected, so the reset byte gets a name
   localparam logic [7:0] CTL_RST = `SSPR_RST_CTL;

   // A shorter half period would sample miso before it crossed over
   if (HALF_DIV <= `SSPR_SYNC_LAT || HALF_DIV > 255)
   begin
      $error("HALF_DIV must lie between 3 and 255");
   end

   function automatic logic pick_bit(input logic [7:0] d, input logic lsb);
      pick_bit = lsb ? d[0] : d[7];
   endfunction

   function automatic logic [7:0] shift_byte(input logic [7:0] d,
                                             input logic       lsb,
                                             input logic       b);
      shift_byte = lsb ? {b, d[7:1]} : {d[6:0], b};
   endfunction

   // System domain: bus slave
   logic [31:0] hrdata_ff;
   logic        wr_pend_ff;
   logic [7:0]  wr_addr_ff;
   logic [7:0]  txb_ff;
   logic [7:0]  rxb_ff;
   sspr_cfg_t   cfg_ff;
   logic        en_ff;
   logic        ovr_ff;
   logic        cmpl_ff;
   logic        tx_full_ff;
   logic        rx_full_ff;
   logic        busy_ff;
   logic        armed_ff;
   logic        irq_ff;
   logic        req_tog_ff;
   logic [7:0]  tx_hold_ff;
   logic [2:0]  done_sync_ff;
   logic        acc;
   logic        rd_ctl;
   logic        rd_rxb;
   logic        wr_txb;
   logic        wr_ctl;
   logic        done_evt;
   logic        issue;
   logic [7:0]  status;
   logic [7:0]  rd_val;
   logic [7:0]  rx_word_ff;
   logic        done_tog_ff;

   assign hrdata       = hrdata_ff;
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;
   assign tx_empty_irq = irq_ff;

   assign acc    = hsel && hready && htrans[1];
   assign rd_ctl = acc && !hwrite && haddr == `SSPR_ADDR_CTL;
   assign rd_rxb = acc && !hwrite && haddr == `SSPR_ADDR_RXB;
   assign wr_txb = wr_pend_ff && wr_addr_ff == `SSPR_ADDR_TXB;
   assign wr_ctl = wr_pend_ff && wr_addr_ff == `SSPR_ADDR_CTL;
   // Done toggle is read only past its first stage
   assign done_evt = done_sync_ff[2] ^ done_sync_ff[1];
   assign issue    = en_ff && tx_full_ff && !busy_ff;

   always_comb
   begin
      status = {cfg_ff.lsb_first, ovr_ff, cmpl_ff, !tx_full_ff,
                rx_full_ff, cfg_ff.cpha, cfg_ff.cpol, en_ff};
      if (haddr == `SSPR_ADDR_RXB)
         rd_val = rxb_ff;
      else if (haddr == `SSPR_ADDR_CTL)
         rd_val = status;
      else
         rd_val = 8'h00;
   end

   // Reads answer in the data phase without waits
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         hrdata_ff <= 32'h0000_0000;
      else if (acc && !hwrite)
         hrdata_ff <= {24'h00_0000, rd_val};
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
      end
      else
      begin
         wr_pend_ff <= acc && hwrite;
         if (acc)
            wr_addr_ff <= haddr;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         txb_ff <= `SSPR_RST_TXB; // see (RL1)
      else if (wr_txb)
         txb_ff <= hwdata[7:0];
   end

   // Reset value of the control byte has only the empty flag set
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         cfg_ff.lsb_first <= CTL_RST[`SSPR_BIT_LSB];
         cfg_ff.cpha      <= CTL_RST[`SSPR_BIT_CPHA];
         cfg_ff.cpol      <= CTL_RST[`SSPR_BIT_CPOL];
         en_ff            <= CTL_RST[`SSPR_BIT_EN]; // see (RL13)
      end
      else if (wr_ctl)
      begin
         cfg_ff.lsb_first <= hwdata[`SSPR_BIT_LSB]; // see (RL3)
         cfg_ff.cpha      <= hwdata[`SSPR_BIT_CPHA]; // see (RL11)
         cfg_ff.cpol      <= hwdata[`SSPR_BIT_CPOL]; // see (RL12)
         en_ff            <= hwdata[`SSPR_BIT_EN]; // see (RL13)
      end
   end

   // Pending byte; disabling drops it so the empty flag reads 1
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || !en_ff)
         tx_full_ff <= 1'b0; // see (RL7)
      else if (wr_txb)
         tx_full_ff <= 1'b1; // see (RL8)
      else if (issue)
         tx_full_ff <= 1'b0; // see (RL8)
   end

   // Data to the link is held still from the toggle until done returns
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         busy_ff    <= 1'b0;
         req_tog_ff <= 1'b0;
         tx_hold_ff <= 8'h00;
      end
      else if (issue)
      begin
         busy_ff    <= 1'b1; // see (RL14)
         req_tog_ff <= !req_tog_ff; // see (RL14)
         tx_hold_ff <= txb_ff;
      end
      else if (done_evt)
         busy_ff <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || !en_ff)
         armed_ff <= 1'b0;
      else if (issue)
         armed_ff <= 1'b1; // see (RL9)
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         irq_ff <= 1'b0;
      else
         irq_ff <= armed_ff && !tx_full_ff; // see (RL8) (RL9)
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         done_sync_ff <= 3'b000;
      else
         done_sync_ff <= {done_sync_ff[1:0], done_tog_ff};
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         rxb_ff <= `SSPR_RST_RXB; // see (RL2)
      else if (done_evt)
         rxb_ff <= rx_word_ff; // see (RL2)
   end

   // Setting wins over a clear in the same cycle for every flag below
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         rx_full_ff <= 1'b0;
      else if (done_evt)
         rx_full_ff <= 1'b1; // see (RL10)
      else if (rd_rxb)
         rx_full_ff <= 1'b0; // see (RL10)
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         ovr_ff <= 1'b0;
      else if (done_evt && rx_full_ff && !rd_rxb)
         ovr_ff <= 1'b1; // see (RL5)
      else if (rd_ctl)
         ovr_ff <= 1'b0; // see (RL5)
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         cmpl_ff <= 1'b0;
      else if (done_evt)
         cmpl_ff <= 1'b1; // see (RL6)
      else if (rd_ctl)
         cmpl_ff <= 1'b0; // see (RL6)
   end

   // Link domain: shifter and serial clock
   logic [1:0]       rst_sync_ff;
   logic [2:0]       req_sync_ff;
   logic [1:0]       miso_sync_ff;
   sspr_cfg_t        cfg_s1_ff;
   sspr_cfg_t        cfg_s2_ff;
   sspr_cfg_t        run_cfg_ff;
   sspr_link_state_t st_ff;
   logic [7:0]       div_ff;
   logic [4:0]       half_ff;
   logic             samp_due_ff;
   logic [7:0]       tx_sh_ff;
   logic [7:0]       rx_sh_ff;
   logic             sclk_ff;
   logic             mosi_ff;
   logic             sel_n_ff;
   logic             link_rst;
   logic             req_evt;
   logic             half_end;
   logic             lead;
   logic             shift_now;
   logic             samp_now;

   assign spi_sclk  = sclk_ff;
   assign spi_mosi  = mosi_ff;
   assign spi_sel_n = sel_n_ff;

   assign link_rst  = rst_sync_ff[1];
   assign req_evt   = req_sync_ff[2] ^ req_sync_ff[1];
   assign half_end  = div_ff == 8'(HALF_DIV - 1);
   assign lead      = !half_ff[0];
   // Modes 0 and 2 (phase 0) shift on trailing edges, except after the last one
   assign shift_now = half_end && half_ff != `SSPR_HALF_EDGES &&
                      (run_cfg_ff.cpha ? lead
                       : (!lead && half_ff != 5'h0F)); // see (RL11)
   // Samples wait out the miso synchroniser latency after their edge
   assign samp_now  = samp_due_ff && div_ff == 8'(`SSPR_SYNC_LAT);

   always_ff @(posedge link_clk)
   begin
      rst_sync_ff  <= {rst_sync_ff[0], sys_rst};
      req_sync_ff  <= {req_sync_ff[1:0], req_tog_ff};
      miso_sync_ff <= {miso_sync_ff[0], spi_miso};
      cfg_s1_ff    <= cfg_ff; // see (RL4)
      cfg_s2_ff    <= cfg_s1_ff;
   end

   always_ff @(posedge link_clk)
   begin
      if (link_rst)
      begin
         st_ff       <= SSPR_IDLE;
         div_ff      <= 8'h00;
         half_ff     <= 5'h00;
         run_cfg_ff  <= '0;
         done_tog_ff <= 1'b0;
      end
      else
      begin
         case (st_ff)
            SSPR_IDLE:
            begin
               div_ff  <= 8'h00;
               half_ff <= 5'h00;
               if (req_evt)
               begin
                  st_ff      <= SSPR_RUN; // see (RL14)
                  run_cfg_ff <= cfg_s2_ff;
               end
            end
            SSPR_RUN:
            begin
               div_ff <= half_end ? 8'h00 : div_ff + 8'h01;
               if (half_end)
               begin
                  if (half_ff == `SSPR_HALF_EDGES)
                  begin
                     st_ff       <= SSPR_IDLE;
                     done_tog_ff <= !done_tog_ff; // see (RL6)
                  end
                  else
                     half_ff <= half_ff + 5'h01;
               end
            end
            default:
               st_ff <= SSPR_IDLE;
         endcase
      end
   end

   // Pins idle at the configured polarity with select released
   always_ff @(posedge link_clk)
   begin
      if (link_rst)
      begin
         sclk_ff  <= 1'b0;
         sel_n_ff <= 1'b1;
      end
      else if (st_ff == SSPR_IDLE)
      begin
         sclk_ff  <= cfg_s2_ff.cpol; // see (RL12)
         sel_n_ff <= !req_evt;
      end
      else if (half_end && half_ff == `SSPR_HALF_EDGES)
         sel_n_ff <= 1'b1;
      else if (half_end)
         sclk_ff <= !sclk_ff; // see (RL12)
   end

   always_ff @(posedge link_clk)
   begin
      if (link_rst)
      begin
         tx_sh_ff <= 8'h00;
         mosi_ff  <= 1'b0;
      end
      else if (st_ff == SSPR_IDLE && req_evt)
      begin
         if (cfg_s2_ff.cpha)
            tx_sh_ff <= tx_hold_ff;
         else
         begin
            // Mode with leading-edge sampling presents bit one early
            mosi_ff  <= pick_bit(tx_hold_ff, cfg_s2_ff.lsb_first);
            tx_sh_ff <= shift_byte(tx_hold_ff, cfg_s2_ff.lsb_first, 1'b0);
         end
      end
      else if (st_ff == SSPR_RUN && shift_now)
      begin
         mosi_ff  <= pick_bit(tx_sh_ff, run_cfg_ff.lsb_first); // see (RL3)
         tx_sh_ff <= shift_byte(tx_sh_ff, run_cfg_ff.lsb_first, 1'b0);
      end
   end

   always_ff @(posedge link_clk)
   begin
      if (link_rst)
         samp_due_ff <= 1'b0;
      else if (st_ff == SSPR_RUN && half_end &&
               half_ff != `SSPR_HALF_EDGES)
         samp_due_ff <= lead ^ run_cfg_ff.cpha; // see (RL11)
      else if (samp_now)
         samp_due_ff <= 1'b0;
   end

   // Shifting the received bit in the same direction as the transmit side keeps order
   always_ff @(posedge link_clk)
   begin
      if (link_rst)
         rx_sh_ff <= 8'h00;
      else if (samp_now)
         rx_sh_ff <= shift_byte(rx_sh_ff, run_cfg_ff.lsb_first,
                                miso_sync_ff[1]); // see (RL3)
   end

   // Held stable from the done toggle until the next byte completes
   always_ff @(posedge link_clk)
   begin
      if (link_rst)
         rx_word_ff <= 8'h00;
      else if (st_ff == SSPR_RUN && half_end &&
               half_ff == `SSPR_HALF_EDGES)
         rx_word_ff <= rx_sh_ff;
   end

endmodule

// file: test/sspr_top_assertions.sv
/*
   Checker for the serial port top: bus answer, read data, irq arming
   and serial frame shape.
   Assumes software keeps the configuration steady across frames.
*/
`timescale 1ns/1ps
`include "sspr_params.svh"

module sspr_chk
#(
   parameter int HALF_DIV = 4
)
(
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        tx_empty_irq,
   input wire logic        link_clk,
   input wire logic        spi_sclk,
   input wire logic        spi_mosi,
   input wire logic        spi_sel_n,
   input wire logic        spi_miso
);
   logic       take;
   logic       wctl_ff;
   logic       wtx_ff;
   logic       seen_ff;
   logic       sclk_ff;
   logic [7:0] cfg_ff;
   logic [4:0] cnt_ff;

   assign take = hsel && hready && htrans[1];

   // Shadow of the control byte, seen only through bus writes
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         wctl_ff <= 1'b0;
         wtx_ff  <= 1'b0;
         seen_ff <= 1'b0;
         cfg_ff  <= 8'h00;
      end
      else
      begin
         wctl_ff <= take && hwrite && haddr == `SSPR_ADDR_CTL;
         wtx_ff  <= take && hwrite && haddr == `SSPR_ADDR_TXB;
         if (wctl_ff)
            cfg_ff <= hwdata[7:0];
         seen_ff <= seen_ff | (wtx_ff & cfg_ff[`SSPR_BIT_EN]);
      end
   end

   // Counts serial clock edges inside one frame
   always_ff @(posedge link_clk)
   begin
      sclk_ff <= spi_sclk;
      cnt_ff  <= spi_sel_n ? 5'h00 : cnt_ff + {4'h0, spi_sclk ^ sclk_ff};
   end

   sequence s_start;
      $fell(spi_sel_n);
   endsequence

   sequence s_end;
      $rose(spi_sel_n);
   endsequence

   a_bus_okay: assert property (
      @(posedge ref_clk) disable iff (sys_rst) hreadyout && !hresp)
      else $error("bus answer not OKAY");
   a_rd_upper: assert property (
      @(posedge ref_clk) disable iff (sys_rst) hrdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_rd_hold: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !$past(take && !hwrite) |-> $stable(hrdata))
      else $error("read data moved without a read");
   a_irq_armed: assert property (
      @(posedge ref_clk) disable iff (sys_rst) tx_empty_irq |-> seen_ff)
      else $error("irq before any byte was sent");
   a_start_idle: assert property (
      @(posedge link_clk) disable iff (sys_rst)
      s_start |-> spi_sclk == cfg_ff[`SSPR_BIT_CPOL])
      else $error("serial clock not idle at frame start");
   a_end_idle: assert property (
      @(posedge link_clk) disable iff (sys_rst)
      s_end |-> spi_sclk == cfg_ff[`SSPR_BIT_CPOL])
      else $error("serial clock not idle at frame end");
   a_edges_16: assert property (
      @(posedge link_clk) disable iff (sys_rst)
      s_end |-> cnt_ff == `SSPR_HALF_EDGES)
      else $error("frame edge count wrong");
   a_mosi_shift: assert property (
      @(posedge link_clk) disable iff (sys_rst)
      !spi_sel_n && $past(!spi_sel_n) && $changed(spi_mosi)
      |-> $changed(spi_sclk))
      else $error("data out moved off a clock edge");
endmodule

bind sspr_top sspr_chk #(.HALF_DIV(HALF_DIV)) u_sspr_chk (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
   .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .tx_empty_irq(tx_empty_irq), .link_clk(link_clk),
   .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_sel_n(spi_sel_n),
   .spi_miso(spi_miso));

// file: test/sspr_peer.sv
/*
   Behavioural serial peer: returns one byte per frame, captures data out.
   Assumes its mode settings match the port's for the running frame.
*/
`timescale 1ns/1ps

module sspr_peer
(
   input  wire logic              spi_sclk,
   input  wire logic              spi_mosi,
   input  wire logic              spi_sel_n,
   input  wire sspr_pkg::sspr_cfg_t cfg,
   input  wire logic [7:0]        tx_byte,
   output logic                   spi_miso,
   output logic [7:0]             rx_byte
);
   import sspr_pkg::*;
   logic [7:0] sh;
   int         nb;

   function automatic logic pick(input int i);
      return cfg.lsb_first ? sh[i] : sh[7 - i];
   endfunction

   initial
   begin
      spi_miso = 1'b0;
      rx_byte  = 8'h00;
   end

   always @(negedge spi_sel_n)
   begin
      sh = tx_byte;
      nb = 0;
      if (!cfg.cpha)
      begin
         spi_miso = pick(0);
         nb = 1;
      end
   end

   always @(spi_sclk)
   begin
      if (!spi_sel_n)
      begin
         if ((spi_sclk != cfg.cpol) != cfg.cpha)
            rx_byte = cfg.lsb_first ? {spi_mosi, rx_byte[7:1]}
                                    : {rx_byte[6:0], spi_mosi};
         else if (nb < 8)
         begin
            spi_miso = pick(nb);
            nb = nb + 1;
         end
      end
   end

   // Released line: inverse of the last bit, so stale data never matches
   always @(posedge spi_sel_n)
      spi_miso = ~spi_miso;
endmodule

// file: test/sspr_top_tb.sv
/*
   Self-checking bench: reset values, all modes in both bit orders,
   overrun with a pending byte, writes to a disabled port.
   Assumes a zero-wait AHB-Lite slave and a free-running link clock.
*/
`timescale 1ns/1ps
`include "sspr_params.svh"

module sspr_top_tb;
   import sspr_pkg::*;
   logic        ref_clk = 1'b0;
   logic        link_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        hsel = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic        hready;
   logic        hreadyout;
   logic        hresp;
   logic        tx_empty_irq;
   logic        spi_sclk;
   logic        spi_mosi;
   logic        spi_sel_n;
   logic        spi_miso;
   sspr_cfg_t   cfg = 3'h0;
   logic [7:0]  peer_tx = 8'h00;
   logic [7:0]  peer_rx;
   int          num_errors = 0;
   int          check_count = 0;

   assign hready = hreadyout;
   always #5 ref_clk = ~ref_clk;
   // Rising edges at odd half nanoseconds never meet the system clock edges
   always #7.5 link_clk = ~link_clk;

   sspr_top #(.HALF_DIV(4)) u_sspr_top (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .tx_empty_irq(tx_empty_irq), .link_clk(link_clk),
      .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_sel_n(spi_sel_n),
      .spi_miso(spi_miso));
   sspr_peer u_sspr_peer (
      .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_sel_n(spi_sel_n),
      .cfg(cfg), .tx_byte(peer_tx), .spi_miso(spi_miso),
      .rx_byte(peer_rx));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask

   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
      bus(a, 1'b0, 32'h0);
      chk(rd, exp, what);
   endtask

   task automatic wait_sel(input logic v);
      int n;
      n = 0;
      while (spi_sel_n !== v && n < 400)
      begin
         @(posedge ref_clk);
         n++;
      end
      chk(spi_sel_n, v, "frame edge");
   endtask

   task automatic frame();
      wait_sel(1'b0);
      wait_sel(1'b1);
      repeat (8) @(posedge ref_clk);
   endtask

   task automatic t_reset();
      rdchk(`SSPR_ADDR_CTL, `SSPR_RST_CTL, "ctl reset");
      rdchk(`SSPR_ADDR_RXB, `SSPR_RST_RXB, "rx reset");
      rdchk(`SSPR_ADDR_TXB, 32'h0, "tx not readable");
      wr(8'hB0, 32'hFF);
      rdchk(8'hB0, 32'h0, "unmapped");
      chk(tx_empty_irq, 1'b0, "irq idle");
      $display("test reset done");
   endtask

   task automatic t_modes();
      logic [7:0] c;
      logic [7:0] d;
      logic [7:0] p;
      for (int i = 0; i < 8; i++)
      begin
         c = {i[2], 4'h0, i[1], i[0], 1'b1};
         d = 8'h1D ^ {i[2:0], 5'h00};
         p = ~d;
         cfg <= {c[7], c[2], c[1]};
         peer_tx <= p;
         // Order, phase and polarity go in with the enable itself
         wr(`SSPR_ADDR_CTL, c);
         rdchk(`SSPR_ADDR_CTL, c | 8'h10, "enabled idle");
         chk(tx_empty_irq, 1'b0, "no irq before byte");
         wr(`SSPR_ADDR_TXB, d);
         frame();
         chk(tx_empty_irq, 1'b1, "irq after byte");
         rdchk(`SSPR_ADDR_CTL, c | 8'h38, "done flags");
         rdchk(`SSPR_ADDR_CTL, c | 8'h18, "complete cleared");
         rdchk(`SSPR_ADDR_RXB, p, "rx byte");
         rdchk(`SSPR_ADDR_CTL, c | 8'h10, "full cleared");
         chk(peer_rx, d, "peer byte");
         wr(`SSPR_ADDR_CTL, 32'h0);
      end
      $display("test modes done");
   endtask

   task automatic t_overrun();
      cfg <= 3'h0;
      peer_tx <= 8'h6C;
      wr(`SSPR_ADDR_CTL, 32'h01);
      wr(`SSPR_ADDR_TXB, 32'hA1);
      repeat (20) @(posedge ref_clk);
      wr(`SSPR_ADDR_TXB, 32'h5E);
      rdchk(`SSPR_ADDR_CTL, 32'h01, "byte pending");
      frame();
      frame();
      rdchk(`SSPR_ADDR_CTL, 32'h79, "overrun");
      rdchk(`SSPR_ADDR_CTL, 32'h19, "overrun cleared");
      rdchk(`SSPR_ADDR_RXB, 32'h6C, "newest byte");
      chk(peer_rx, 8'h5E, "pending byte sent");
      wr(`SSPR_ADDR_CTL, 32'h0);
      $display("test overrun done");
   endtask

   task automatic t_disabled();
      int lows;
      lows = 0;
      wr(`SSPR_ADDR_TXB, 32'h33);
      repeat (150)
      begin
         @(posedge ref_clk);
         lows += (spi_sel_n !== 1'b1);
      end
      chk(lows, 0, "no frame while off");
      rdchk(`SSPR_ADDR_CTL, `SSPR_RST_CTL, "off status");
      chk(tx_empty_irq, 1'b0, "irq disarmed");
      $display("test disabled done");
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      // Longer than two cycles: the link side needs three of its own edges
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      t_reset();
      t_modes();
      t_overrun();
      t_disabled();
      close_out();
   end

   initial
   begin
      #200000;
      num_errors++;
      close_out();
   end
endmodule
